// ==== design/i2cism_ctrl.sv ====
// I2C interrupt status, mask, queues and link-side event crossing
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/100ps
module i2cism_ctrl
    import i2cism_pkg::*;
(
    // System clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Peripheral register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link domain inputs
    input wire logic link_clk,
    input wire logic link_rst,
    input wire i2cism_evt_t link_evt,
    input wire i2cism_link_data_t link_data,
    input wire logic link_active,
    // Link domain outputs
    output logic scl_o,
    output logic scl_oe_n,
    output logic link_enable,
    // System side outputs
    output logic [DATA_W-1:0] tx_byte,
    output logic irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic enable;
    logic internal_enable_state;
    logic [THR_W-1:0] tx_level_threshold;
    logic [THR_W-1:0] rx_level_threshold;
    logic [STAT_W-1:0] interrupt_mask;
    logic [RAW_W-1:0] raw;
    logic [CAUSE_W-1:0] abort_cause_register;
    i2cism_link_data_t link_hold;
    logic en_meta;
    logic act_meta;
    logic act_sync;
    logic [EVT_W-1:0] evt_vec;
    i2cism_evt_t evt_p;
    logic clr_link_p;
    logic [DATA_W-1:0] tx_head;
    logic [LEVEL_W-1:0] tx_level;
    logic tx_full;
    logic tx_empty_q;
    logic [DATA_W-1:0] rx_head;
    logic [LEVEL_W-1:0] rx_level;
    logic rx_full_q;
    logic rx_empty_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Access phases and address hits
    wire apb_setup = psel && !penable;
    wire apb_access = psel && penable && pready;
    wire acc_wr = apb_access && pwrite;
    wire acc_rd = apb_access && !pwrite;
    wire hit_data = (paddr == ADDR_DATA_CMD);
    wire hit_status = (paddr == ADDR_STATUS);
    wire hit_mask = (paddr == ADDR_MASK);
    wire hit_rx_level_threshold = (paddr == ADDR_RX_LEVEL_THRESHOLD);
    wire hit_tx_tl = (paddr == ADDR_TX_TL);
    wire hit_clr_rd = (paddr == ADDR_CLR_RD_REQ);
    wire hit_clr_abrt = (paddr == ADDR_CLR_TX_ABRT);
    wire hit_clr_done = (paddr == ADDR_CLR_RX_DONE);
    wire hit_enable = (paddr == ADDR_ENABLE);
    wire hit_cause = (paddr == ADDR_ABRT_CAUSE);
    wire hit_any = hit_data || hit_status || hit_mask || hit_rx_level_threshold || hit_tx_tl
        || hit_clr_rd || hit_clr_abrt || hit_clr_done || hit_enable || hit_cause;
    // Side-effect strobes
    wire wr_data = acc_wr && hit_data;
    wire rd_data = acc_rd && hit_data;
    wire clr_rd_acc = acc_rd && hit_clr_rd;
    wire clr_abrt_acc = acc_rd && hit_clr_abrt;
    wire clr_done_acc = acc_rd && hit_clr_done;
    // Masked status seen by software and the interrupt line
    wire [STAT_W-1:0] status = {4'h0, raw} & interrupt_mask;
    // Read data selection
    wire [31:0] rd_value =
        hit_status ? 32'(status) :
        hit_mask ? 32'(interrupt_mask) :
        hit_data ? 32'(rx_head) :
        hit_rx_level_threshold ? 32'(rx_level_threshold) :
        hit_tx_tl ? 32'(tx_level_threshold) :
        hit_clr_rd ? 32'(raw[BIT_RD_REQ]) :
        hit_clr_abrt ? 32'(raw[BIT_TX_ABRT]) :
        hit_clr_done ? 32'(raw[BIT_RX_DONE]) :
        hit_enable ? 32'(enable) :
        hit_cause ? 32'(abort_cause_register) : 32'h0000_0000;

    // Bus answer: zero wait states, error on unmapped address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !hit_any;
            if (apb_setup) begin
                prdata <= rd_value;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Enable, thresholds and mask written by software
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enable <= 1'b0;
            tx_level_threshold <= THR_RESET;
            rx_level_threshold <= THR_RESET;
            interrupt_mask <= MASK_RESET;
        end else if (acc_wr) begin
            if (hit_enable) begin
                enable <= pwdata[BIT_ENABLE];
            end else if (hit_tx_tl) begin
                tx_level_threshold <= pwdata[THR_W-1:0];
            end else if (hit_rx_level_threshold) begin
                rx_level_threshold <= pwdata[THR_W-1:0];
            end else if (hit_mask) begin
                interrupt_mask <= pwdata[STAT_W-1:0];
            end
        end
    end

    // Internal enable drops only once disabled and the link is idle
    wire next_internal_enable = enable || (internal_enable_state && act_sync);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            internal_enable_state <= 1'b0;
        end else begin
            internal_enable_state <= next_internal_enable;
        end
    end

    // ------------------------------------------------------------------
    // Clock crossings
    // ------------------------------------------------------------------
    // Link events into the system domain, one crossing per event
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_evt
            i2cism_evt_sync u_evt (
                .src_clk(link_clk),
                .src_rst(link_rst),
                .src_pulse(link_evt[gi]),
                .dst_clk(sys_clk),
                .dst_rst(rst),
                .dst_pulse(evt_vec[gi])
            );
        end
    endgenerate
    assign evt_p = i2cism_evt_t'(evt_vec);
    // Read request release back to the link
    i2cism_evt_sync u_clr_rd (
        .src_clk(sys_clk),
        .src_rst(rst),
        .src_pulse(clr_rd_acc),
        .dst_clk(link_clk),
        .dst_rst(link_rst),
        .dst_pulse(clr_link_p)
    );
    // Link activity level into the system domain
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            act_meta <= 1'b0;
            act_sync <= 1'b0;
        end else begin
            act_meta <= link_active;
            act_sync <= act_meta;
        end
    end

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    // Data held stable until the crossed event has been consumed
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            link_hold <= '0;
        end else begin
            if (link_evt.rx_byte) begin
                link_hold.rx_data <= link_data.rx_data;
            end
            if (link_evt.abort) begin
                link_hold.abort_cause <= link_data.abort_cause;
            end
        end
    end

    // Enable level toward the link and clock stretch on read request
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            en_meta <= 1'b0;
            link_enable <= 1'b0;
            scl_o <= 1'b0;
            scl_oe_n <= 1'b1;
        end else begin
            en_meta <= enable;
            link_enable <= en_meta;
            scl_o <= 1'b0;
            if (link_evt.rd_req) begin
                scl_oe_n <= 1'b0;
            end else if (clr_link_p) begin
                scl_oe_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Queues
    // ------------------------------------------------------------------
    // Transmit side is held empty while disabled or aborted
    wire tx_flush = !enable || raw[BIT_TX_ABRT];
    wire tx_push = wr_data && !tx_flush;
    wire tx_pop = evt_p.tx_take && !tx_empty_q;
    i2cism_queue u_tx_queue (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(tx_flush),
        .push(tx_push),
        .push_data(pwdata[DATA_W-1:0]),
        .pop(tx_pop),
        .head(tx_head),
        .level(tx_level),
        .full(tx_full),
        .empty(tx_empty_q)
    );
    // Receive side is held empty while disabled
    wire rx_flush = !enable;
    i2cism_queue u_rx_queue (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(rx_flush),
        .push(evt_p.rx_byte),
        .push_data(link_hold.rx_data),
        .pop(rd_data),
        .head(rx_head),
        .level(rx_level),
        .full(rx_full_q),
        .empty(rx_empty_q)
    );

    // Byte handed to the link when it takes one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_byte <= '0;
        end else if (tx_pop) begin
            tx_byte <= tx_head;
        end
    end

    // ------------------------------------------------------------------
    // Status conditions
    // ------------------------------------------------------------------
    // Next raw conditions; a set always wins over a clear
    logic [RAW_W-1:0] next_raw;
    assign next_raw[BIT_RX_UNDER] = (rd_data && rx_empty_q)
        || (raw[BIT_RX_UNDER] && internal_enable_state);
    assign next_raw[BIT_RX_OVER] = (evt_p.rx_byte && rx_full_q)
        || (raw[BIT_RX_OVER] && internal_enable_state);
    assign next_raw[BIT_RX_FULL] = enable
        && (rx_level >= {1'b0, rx_level_threshold});
    assign next_raw[BIT_TX_OVER] = (wr_data && tx_full)
        || (raw[BIT_TX_OVER] && internal_enable_state);
    assign next_raw[BIT_TX_EMPTY] = enable
        ? (tx_level <= {1'b0, tx_level_threshold}) : act_sync;
    assign next_raw[BIT_RD_REQ] = evt_p.rd_req
        || (raw[BIT_RD_REQ] && !clr_rd_acc);
    assign next_raw[BIT_TX_ABRT] = evt_p.abort
        || (raw[BIT_TX_ABRT] && !clr_abrt_acc);
    assign next_raw[BIT_RX_DONE] = evt_p.nack_done
        || (raw[BIT_RX_DONE] && !clr_done_acc && internal_enable_state);
    // Condition flags and interrupt line
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            raw <= RAW_RESET;
            irq <= 1'b0;
        end else begin
            raw <= next_raw;
            irq <= |status;
        end
    end

    // Abort cause captured from the link, dropped by the clear read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            abort_cause_register <= CAUSE_RESET;
        end else if (evt_p.abort) begin
            abort_cause_register <= link_hold.abort_cause;
        end else if (clr_abrt_acc) begin
            abort_cause_register <= CAUSE_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_rx_done_set: assert property (@(posedge sys_clk) disable iff (rst)
        evt_p.nack_done |=> raw[BIT_RX_DONE])
        else $error("slave transmit done not flagged");
    a_abort_cause: assert property (@(posedge sys_clk) disable iff (rst)
        evt_p.abort |=> raw[BIT_TX_ABRT]
            && abort_cause_register == $past(link_hold.abort_cause))
        else $error("abort flag or cause not recorded");
    a_abort_flush: assert property (@(posedge sys_clk) disable iff (rst)
        raw[BIT_TX_ABRT] |=> tx_level == '0)
        else $error("transmit queue not empty during abort");
    a_scl_hold: assert property (@(posedge link_clk) disable iff (link_rst)
        link_evt.rd_req && !clr_link_p |=> !scl_oe_n)
        else $error("clock not stretched on read request");
    a_rd_req_clear: assert property (@(posedge sys_clk) disable iff (rst)
        clr_rd_acc && !evt_p.rd_req |=> !raw[BIT_RD_REQ])
        else $error("read request flag survived clear read");
    a_tx_empty_level: assert property (@(posedge sys_clk) disable iff (rst)
        enable && tx_level <= {1'b0, tx_level_threshold} |=> raw[BIT_TX_EMPTY])
        else $error("transmit threshold flag missing");
    a_tx_over_set: assert property (@(posedge sys_clk) disable iff (rst)
        wr_data && tx_full && !tx_pop && !tx_flush |=> raw[BIT_TX_OVER] && tx_level == LEVEL_FULL)
        else $error("transmit overflow not flagged");
    a_rx_full_off: assert property (@(posedge sys_clk) disable iff (rst)
        !enable |=> !raw[BIT_RX_FULL] && rx_level == '0)
        else $error("receive threshold flag set while disabled");
    a_rx_under_set: assert property (@(posedge sys_clk) disable iff (rst)
        rd_data && rx_empty_q |=> raw[BIT_RX_UNDER])
        else $error("receive underflow not flagged");
    a_flags_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !internal_enable_state && !apb_access && !evt_p.rx_byte
            |=> !raw[BIT_TX_OVER] && !raw[BIT_RX_OVER] && !raw[BIT_RX_UNDER])
        else $error("overflow flags kept after internal disable");
    a_irq_follows: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 irq == $past(|status))
        else $error("interrupt output does not follow status");

endmodule : i2cism_ctrl

// ==== design/i2cism_evt_sync.sv ====
// Toggle-based crossing of a one-cycle event between two clock domains
`timescale 1ns/100ps
module i2cism_evt_sync
    import i2cism_pkg::*;
(
    // Source domain
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_pulse,
    // Destination domain
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic dst_pulse
);

    logic src_tgl;
    logic dst_meta;
    logic dst_sync;
    logic dst_last;

    // Source flips a level per event
    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            src_tgl <= 1'b0;
        end else if (src_pulse) begin
            src_tgl <= ~src_tgl;
        end
    end

    // Two-stage synchroniser, then a delayed copy for the edge
    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            dst_meta <= 1'b0;
            dst_sync <= 1'b0;
            dst_last <= 1'b0;
        end else begin
            dst_meta <= src_tgl;
            dst_sync <= dst_meta;
            dst_last <= dst_sync;
        end
    end

    // Any change of the synced level is one event
    assign dst_pulse = dst_sync ^ dst_last;

    a_pulse_single: assert property (@(posedge dst_clk) disable iff (dst_rst)
        dst_pulse |=> !dst_pulse)
        else $error("crossed event lasted more than one cycle");

endmodule : i2cism_evt_sync

// ==== design/i2cism_queue.sv ====
// Thirty-two entry byte queue with flush, used for both directions
`timescale 1ns/100ps
module i2cism_queue
    import i2cism_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic flush,
    input wire logic push,
    input wire logic [DATA_W-1:0] push_data,
    input wire logic pop,
    // State
    output logic [DATA_W-1:0] head,
    output logic [LEVEL_W-1:0] level,
    output logic full,
    output logic empty
);

    logic [DATA_W-1:0] store [QUEUE_DEPTH];
    logic [QUEUE_AW-1:0] wr_ptr;
    logic [QUEUE_AW-1:0] rd_ptr;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    // Fill state and head
    assign full = (level == LEVEL_FULL);
    assign empty = (level == '0);
    assign head = store[rd_ptr];

    // Pointers and level; flush empties the queue at once
    always_ff @(posedge sys_clk) begin
        if (rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                level <= level + 1'b1;
            end else if (do_pop && !do_push) begin
                level <= level - 1'b1;
            end
        end
    end

    // Storage, no reset needed
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            store[wr_ptr] <= push_data;
        end
    end

    a_level_bound: assert property (@(posedge sys_clk) disable iff (rst)
        level <= LEVEL_FULL)
        else $error("queue level above depth");

    a_flush_empties: assert property (@(posedge sys_clk) disable iff (rst)
        flush |=> empty && level == '0)
        else $error("queue not empty after flush");

endmodule : i2cism_queue

// ==== shared/i2cism_pkg.sv ====
// Shared constants and types for the I2C interrupt status and mask block
package i2cism_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_DATA_CMD = 32'h5000_1310;
    localparam logic [31:0] ADDR_STATUS = 32'h5000_132C;
    localparam logic [31:0] ADDR_MASK = 32'h5000_1330;
    localparam logic [31:0] ADDR_RX_LEVEL_THRESHOLD = 32'h5000_1338;
    localparam logic [31:0] ADDR_TX_TL = 32'h5000_133C;
    localparam logic [31:0] ADDR_CLR_RD_REQ = 32'h5000_1350;
    localparam logic [31:0] ADDR_CLR_TX_ABRT = 32'h5000_1354;
    localparam logic [31:0] ADDR_CLR_RX_DONE = 32'h5000_1358;
    localparam logic [31:0] ADDR_ENABLE = 32'h5000_136C;
    localparam logic [31:0] ADDR_ABRT_CAUSE = 32'h5000_1380;

    // ------------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int QUEUE_DEPTH = 32;
    localparam int QUEUE_AW = 5;
    localparam int LEVEL_W = 6;
    localparam int THR_W = 5;
    localparam int CAUSE_W = 16;
    localparam int STAT_W = 12;
    localparam int RAW_W = 8;
    localparam int EVT_W = 5;

    // ------------------------------------------------------------------
    // Status and enable bit positions
    // ------------------------------------------------------------------
    localparam int BIT_RX_UNDER = 0;
    localparam int BIT_RX_OVER = 1;
    localparam int BIT_RX_FULL = 2;
    localparam int BIT_TX_OVER = 3;
    localparam int BIT_TX_EMPTY = 4;
    localparam int BIT_RD_REQ = 5;
    localparam int BIT_TX_ABRT = 6;
    localparam int BIT_RX_DONE = 7;
    localparam int BIT_ENABLE = 0;

    // ------------------------------------------------------------------
    // Reset values and full queue level
    // ------------------------------------------------------------------
    localparam logic [STAT_W-1:0] MASK_RESET = 12'h8FF;
    localparam logic [RAW_W-1:0] RAW_RESET = 8'h00;
    localparam logic [THR_W-1:0] THR_RESET = 5'h00;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 16'h0000;
    localparam logic [LEVEL_W-1:0] LEVEL_FULL = 6'h20;

    // ------------------------------------------------------------------
    // Link-side carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rx_byte;
        logic tx_take;
        logic nack_done;
        logic abort;
        logic rd_req;
    } i2cism_evt_t;

    typedef struct packed {
        logic [DATA_W-1:0] rx_data;
        logic [CAUSE_W-1:0] abort_cause;
    } i2cism_link_data_t;

endpackage : i2cism_pkg

// ==== verif/i2cism_ctrl_tb.sv ====
// Self-checking testbench for the interrupt status and mask block
`timescale 1ns/100ps
module i2cism_ctrl_tb
    import i2cism_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and clocks
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic link_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic scl_o;
    logic scl_oe_n;
    logic link_enable;
    logic [DATA_W-1:0] tx_byte;
    logic irq;
    i2cism_evt_t link_evt;
    i2cism_link_data_t link_data;
    logic link_active;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int tests_run = 0;
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Link clock, unrelated phase
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    i2cism_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk), .link_rst(link_rst), .link_evt(link_evt),
        .link_data(link_data), .link_active(link_active), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .link_enable(link_enable), .tx_byte(tx_byte), .irq(irq));
    i2cism_link_model link_u (.link_clk(link_clk), .link_evt(link_evt),
        .link_data(link_data), .link_active(link_active));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // One bus transfer; result left in rd and err
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(negedge sys_clk);
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge sys_clk);
        penable = 1'b1;
        for (k = 0; k < 8 && pready !== 1'b1; k++) begin
            @(negedge sys_clk);
        end
        if (k == 8) begin
            errors++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        @(negedge sys_clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask : apb
    task automatic stat(input logic [11:0] e);
        apb(1'b0, ADDR_STATUS, '0);
        chk("status", rd, {20'h0, e});
    endtask : stat
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        link_rst = 1'b0;
        apb(1'b0, ADDR_MASK, '0);
        chk("mask", rd, 32'h0000_08FF);
        stat(12'h000);
        apb(1'b0, 32'h5000_1334, '0);
        chk("unmapped error", err, 1'b1);
        link_u.set_active(1'b1);
        stat(12'h010);
        chk("irq", irq, 1'b1);
        apb(1'b1, ADDR_MASK, '0);
        stat(12'h000);
        chk("irq", irq, 1'b0);
        apb(1'b1, ADDR_MASK, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_MASK, '0);
        chk("mask", rd, 32'h0000_0FFF);
        $display("test reset and mask done");
        apb(1'b1, ADDR_RX_LEVEL_THRESHOLD, 32'h1);
        apb(1'b1, ADDR_TX_TL, '0);
        apb(1'b1, ADDR_ENABLE, 32'h1);
        stat(12'h010);
        apb(1'b0, ADDR_DATA_CMD, '0);
        stat(12'h011);
        chk("link enable", link_enable, 1'b1);
        apb(1'b0, ADDR_RX_LEVEL_THRESHOLD, '0);
        chk("rx threshold", rd, 32'h1);
        for (i = 0; i < 33; i++) begin
            link_u.send(5'h10, {8'(i), 16'h0});
        end
        stat(12'h017);
        for (i = 0; i < 32; i++) begin
            apb(1'b0, ADDR_DATA_CMD, '0);
            chk("rx byte", rd[7:0], 8'(i));
        end
        stat(12'h013);
        $display("test receive done");
        for (i = 0; i < 33; i++) begin
            apb(1'b1, ADDR_DATA_CMD, 32'hA0 + i);
        end
        stat(12'h00B);
        link_u.send(5'h08, '0);
        chk("tx byte", tx_byte, 8'hA0);
        link_u.send(5'h02, 24'h00_0123);
        stat(12'h05B);
        apb(1'b0, ADDR_ABRT_CAUSE, '0);
        chk("cause", rd, 32'h0123);
        apb(1'b1, ADDR_DATA_CMD, 32'h55);
        stat(12'h05B);
        apb(1'b0, ADDR_CLR_TX_ABRT, '0);
        chk("abort clear", rd, 32'h1);
        apb(1'b0, ADDR_ABRT_CAUSE, '0);
        chk("cause", rd, 32'h0);
        apb(1'b1, ADDR_DATA_CMD, 32'h55);
        stat(12'h00B);
        $display("test transmit and abort done");
        link_u.send(5'h01, '0);
        chk("scl hold", {scl_oe_n, scl_o}, 2'b00);
        stat(12'h02B);
        apb(1'b1, ADDR_DATA_CMD, 32'h66);
        apb(1'b0, ADDR_CLR_RD_REQ, '0);
        chk("request clear", rd, 32'h1);
        repeat (10) @(negedge sys_clk);
        chk("scl hold", scl_oe_n, 1'b1);
        stat(12'h00B);
        link_u.send(5'h04, '0);
        stat(12'h08B);
        apb(1'b0, ADDR_CLR_RX_DONE, '0);
        chk("done clear", rd, 32'h1);
        stat(12'h00B);
        link_u.send(5'h04, '0);
        $display("test read request done");
        link_u.send(5'h10, '0);
        stat(12'h08F);
        apb(1'b1, ADDR_ENABLE, '0);
        stat(12'h09B);
        link_u.set_active(1'b0);
        stat(12'h000);
        chk("link enable", link_enable, 1'b0);
        chk("irq", irq, 1'b0);
        $display("test disable done");
        test_done();
    end
endmodule : i2cism_ctrl_tb

// ==== verif/i2cism_link_model.sv ====
// Link-side model of the remote bus partner driving event pulses
`timescale 1ns/100ps
module i2cism_link_model
    import i2cism_pkg::*;
(
    // Link clock
    input wire logic link_clk,
    // Pins towards the block
    output i2cism_evt_t link_evt,
    output i2cism_link_data_t link_data,
    output logic link_active
);
    // Idle values at time zero
    initial begin
        link_evt = '0;
        link_data = '0;
        link_active = 1'b0;
    end
    // One pulse, then data inverted and spacing kept so pulses never merge
    task automatic send(input i2cism_evt_t e, input logic [23:0] d);
        @(negedge link_clk);
        link_evt = e;
        link_data = d;
        @(negedge link_clk);
        link_evt = '0;
        link_data = ~d;
        repeat (5) @(negedge link_clk);
    endtask : send
    // Engine activity level, given time to cross
    task automatic set_active(input logic a);
        @(negedge link_clk);
        link_active = a;
        repeat (4) @(negedge link_clk);
    endtask : set_active
endmodule : i2cism_link_model
